// File: include/flash_ctrl_pkg.sv
package flash_ctrl_pkg;

	localparam int ADDR_W = 16;
	localparam int DATA_W = 8;

	// register locations seen by the cpu core
	localparam logic [15:0] STAGED_ADDR     = 16'h0FD0;
	localparam logic [15:0] COMMIT_ADDR     = 16'h0FD1;
	localparam logic [15:0] STANDBY_ADDR    = 16'h0FD2;
	localparam logic [15:0] PORT_CTRL_ADDR  = 16'h0FD3;
	localparam logic [15:0] SYS_CFG3_ADDR   = 16'h0FC0;
	localparam logic [15:0] SYS_COMMIT_ADDR = 16'h0FC1;

	// commit keys and field codes
	localparam logic [7:0] CFG_KEY   = 8'hD5;
	localparam logic [7:0] SYS_KEY   = 8'hD4;
	localparam logic [2:0] PROG_EN   = 3'h5;
	localparam logic [2:0] PROG_PROT = 3'h2;
	localparam logic [1:0] AREA_STD  = 2'h0;
	localparam logic [1:0] AREA_CODE = 2'h2;

	// staged / shadow configuration layout
	localparam int PROG_MSB    = 7;
	localparam int PROG_LSB    = 5;
	localparam int BOOT_BIT    = 4;
	localparam int AREA_MSB    = 3;
	localparam int AREA_LSB    = 2;
	localparam int MON_EN_BIT  = 5;
	localparam logic [7:0] STAGED_RESET = 8'h40;

	// system configuration and port control layout
	localparam int SYS_RAM_BIT   = 0;
	localparam int SYS_VEC_BIT   = 1;
	localparam logic [7:0] SYS_RESET = 8'h00;
	localparam int PORT_GEN_BIT  = 0;
	localparam int PORT_SCLK_BIT = 1;

	// address map
	localparam logic [15:0] WIN_LO       = 16'hC000;
	localparam logic [15:0] FLASH_LO     = 16'h1000;
	localparam logic [15:0] BOOT_LO      = 16'h1000;
	localparam logic [15:0] BOOT_DATA_HI = 16'h17FF;
	localparam logic [15:0] BOOT_CODE_HI = 16'h1FFF;
	localparam logic [15:0] RAM_LO       = 16'h0040;
	localparam logic [15:0] RAM_HI       = 16'h0FBF;

	// strap sampling: edges after release before the synchronised level is valid
	localparam logic [1:0] STRAP_SYNC_CYCLES = 2'h2;

	typedef enum logic [3:0] {
		TGT_NONE  = 4'b0001,
		TGT_FLASH = 4'b0010,
		TGT_RAM   = 4'b0100,
		TGT_BOOT  = 4'b1000
	} target_type;

	typedef enum logic [2:0] {
		OP_REG_WR = 3'h0,
		OP_REG_RD = 3'h1,
		OP_MEM_RD = 3'h2,
		OP_MEM_WR = 3'h3,
		OP_FETCH  = 3'h4,
		OP_IRQ    = 3'h5,
		OP_UNLOCK = 3'h6,
		OP_LOCK   = 3'h7
	} op_type;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0001,
		ST_DRAIN  = 4'b0010,
		ST_STAGE  = 4'b0100,
		ST_COMMIT = 4'b1000
	} host_state_type;

endpackage

// File: include/cpu_flash_if.sv
`timescale 1ns/1ps
interface cpu_flash_if;
	// register transfers
	logic        reg_wr;
	logic        reg_rd;
	logic [15:0] reg_addr;
	logic [7:0]  reg_wdata;
	logic        reg_src_ram;
	logic [7:0]  reg_rdata;
	logic        reg_rvalid;
	// memory transfers and fetches
	logic        mem_req;
	logic        mem_wr;
	logic        mem_code;
	logic [15:0] mem_addr;
	logic [7:0]  mem_wdata;
	// interrupt vector request and status seen by the core
	logic        irq_vec;
	logic        vec_from_ram;
	logic        cmd_armed;
	logic        flash_busy;

	modport device (
		input  reg_wr, reg_rd, reg_addr, reg_wdata, reg_src_ram,
		input  mem_req, mem_wr, mem_code, mem_addr, mem_wdata, irq_vec,
		output reg_rdata, reg_rvalid, vec_from_ram, cmd_armed, flash_busy
	);

	modport host (
		output reg_wr, reg_rd, reg_addr, reg_wdata, reg_src_ram,
		output mem_req, mem_wr, mem_code, mem_addr, mem_wdata, irq_vec,
		input  reg_rdata, reg_rvalid, vec_from_ram, cmd_armed, flash_busy
	);
endinterface

// File: src/flash_map_protect_ctrl.sv
`timescale 1ns/1ps
// Operation
// - 101 then key D5 enables commands
// - 010 then key commits write protection
// - protected: command writes and toggle ignored
// - reset loads program field with 010
// - protection never aborts running sequence
// - core drains sequences before protecting
// - core keeps protection on normally
// - flash writes only through data space
// - area 10 mirrors code window into data
// - both upper windows hit same bytes
// - ram bit plus D4 maps ram
// - serial mode always maps ram
// - boot bit maps boot rom 1000-17FF
// - serial mode boot rom fixed ranges
// - serial mode boot bit reads one
// - standby writes only from ram code
// - flash access in standby resets
// - flash vector interrupt clears standby
// - ram vector interrupt keeps standby
// - serial mode holds port inputs fixed
// - enables release clock and general inputs
// - normal mode ignores port control
// - staged config copied on key only
module flash_map_protect_ctrl
	import flash_ctrl_pkg::*;
#(
	parameter int PORT_W = 8
) (
	input  wire logic              clk,
	input  wire logic              resetn,
	cpu_flash_if.device            bus,
	input  wire logic              array_busy,
	input  wire logic              spm_pin,
	input  wire logic [PORT_W-1:0] port_pins,
	input  wire logic              serial_clock_pin,
	input  wire logic              serial_receive_pin,
	output logic                   flash_cs,
	output logic                   flash_we,
	output logic                   flash_code_bank,
	output logic [15:0]            flash_addr,
	output logic [7:0]             flash_wdata,
	output logic                   ram_cs,
	output logic                   boot_cs,
	output logic                   cmd_enable,
	output logic                   standby_reset,
	output logic                   serial_mode,
	output logic [PORT_W-1:0]      port_gated,
	output logic                   serial_clock_gated,
	output logic                   serial_receive_gated
);

	localparam int SYNC_W = PORT_W + 3;

	// refused at elaboration: the gating needs at least one port bit
	if (PORT_W < 1) begin
		$error("PORT_W must be at least 1");
	end

	logic [SYNC_W-1:0] sync_meta;
	logic [SYNC_W-1:0] sync_pins;
	logic [1:0]        strap_cnt;
	logic [7:0]        flash_staged_config;
	logic [7:0]        shadow_config;
	logic [7:0]        system_config_three;
	logic [7:0]        system_shadow;
	logic              standby_bit;
	logic [1:0]        port_input_ctrl_reg;
	logic              busy_q;
	target_type        next_target;
	logic              next_code_bank;
	logic              boot_on;
	logic              ram_in_code;
	logic              area_code;
	logic              vec_ram;
	logic [15:0]       boot_hi;

	// every pin passes two flops; only sync_pins is read by logic
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			sync_meta <= '0;
			sync_pins <= '0;
		end else begin
			sync_meta <= {spm_pin, serial_clock_pin, serial_receive_pin, port_pins};
			sync_pins <= sync_meta;
		end
	end

	// strap caught once the synchroniser holds a valid level after release
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			strap_cnt   <= 2'h0;
			serial_mode <= 1'b0;
		end else if (strap_cnt != 2'h3) begin
			strap_cnt <= strap_cnt + 2'h1;
			if (strap_cnt == STRAP_SYNC_CYCLES) begin
				serial_mode <= sync_pins[SYNC_W-1];
			end
		end
	end

	// staged flash configuration, written freely, acts only via shadow
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flash_staged_config <= STAGED_RESET;
		end else if (bus.reg_wr && bus.reg_addr == STAGED_ADDR) begin
			flash_staged_config <= bus.reg_wdata;
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			shadow_config <= STAGED_RESET;
		end else if (bus.reg_wr && bus.reg_addr == COMMIT_ADDR && bus.reg_wdata == CFG_KEY) begin
			shadow_config <= flash_staged_config;
		end
	end

	// system map: staged ram/vector bits, active after their own key
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			system_config_three <= SYS_RESET;
			system_shadow       <= SYS_RESET;
		end else begin
			if (bus.reg_wr && bus.reg_addr == SYS_CFG3_ADDR) begin
				system_config_three <= bus.reg_wdata;
			end
			if (bus.reg_wr && bus.reg_addr == SYS_COMMIT_ADDR && bus.reg_wdata == SYS_KEY) begin
				system_shadow <= system_config_three;
			end
		end
	end

	// software write wins over the interrupt clear in the same cycle
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			standby_bit <= 1'b0;
		end else if (bus.reg_wr && bus.reg_addr == STANDBY_ADDR && bus.reg_src_ram) begin
			standby_bit <= bus.reg_wdata[0];
		end else if (bus.irq_vec && !vec_ram) begin
			standby_bit <= 1'b0;
		end
	end

	// port control only writable in serial mode
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port_input_ctrl_reg <= 2'b00;
		end else if (bus.reg_wr && bus.reg_addr == PORT_CTRL_ADDR && serial_mode) begin
			port_input_ctrl_reg <= bus.reg_wdata[1:0];
		end
	end

	// effective map settings
	// only 101 arms commands
	assign cmd_enable  = (shadow_config[PROG_MSB:PROG_LSB] == PROG_EN);
	assign area_code   = (shadow_config[AREA_MSB:AREA_LSB] == AREA_CODE);
	assign ram_in_code = serial_mode | system_shadow[SYS_RAM_BIT];
	assign boot_on     = serial_mode | shadow_config[BOOT_BIT];
	assign vec_ram     = system_shadow[SYS_VEC_BIT];
	assign boot_hi     = (serial_mode && bus.mem_code) ? BOOT_CODE_HI : BOOT_DATA_HI;

	// address decode for one memory transfer or fetch
	always_comb begin
		next_target    = TGT_NONE;
		next_code_bank = bus.mem_code;
		if (!bus.mem_code && bus.mem_addr >= RAM_LO && bus.mem_addr <= RAM_HI) begin
			next_target = TGT_RAM;
		end else if (bus.mem_code && ram_in_code && bus.mem_addr >= RAM_LO
				&& bus.mem_addr <= RAM_HI) begin
			next_target = TGT_RAM;
		end else if (boot_on && bus.mem_addr >= BOOT_LO && bus.mem_addr <= boot_hi) begin
			next_target = TGT_BOOT;
		end else if (bus.mem_addr >= FLASH_LO) begin
			next_target = TGT_FLASH;
			if (!bus.mem_code && area_code && bus.mem_addr >= WIN_LO) begin
				next_code_bank = 1'b1;
			end
		end
	end

	// registered strobes toward the memories
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			flash_cs        <= 1'b0;
			flash_we        <= 1'b0;
			ram_cs          <= 1'b0;
			boot_cs         <= 1'b0;
			standby_reset   <= 1'b0;
			flash_code_bank <= 1'b0;
			flash_addr      <= 16'h0000;
			flash_wdata     <= 8'h00;
		end else begin
			flash_cs <= bus.mem_req && next_target == TGT_FLASH && !standby_bit;
			flash_we <= bus.mem_req && next_target == TGT_FLASH && !standby_bit
				&& bus.mem_wr && !bus.mem_code && cmd_enable;
			ram_cs  <= bus.mem_req && next_target == TGT_RAM;
			boot_cs <= bus.mem_req && next_target == TGT_BOOT;
			standby_reset   <= bus.mem_req && next_target == TGT_FLASH && standby_bit;
			flash_code_bank <= next_code_bank;
			flash_addr      <= bus.mem_addr;
			flash_wdata     <= bus.mem_wdata;
		end
	end

	// register read port, answered one cycle after the request
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			bus.reg_rdata  <= 8'h00;
			bus.reg_rvalid <= 1'b0;
			busy_q         <= 1'b0;
		end else begin
			bus.reg_rvalid <= bus.reg_rd;
			busy_q         <= array_busy;
			if (bus.reg_addr == STAGED_ADDR) begin
				bus.reg_rdata <= flash_staged_config | (8'(serial_mode) << BOOT_BIT);
			end else if (bus.reg_addr == COMMIT_ADDR) begin
				// monitor of the active shadow
				bus.reg_rdata <= {2'b00, cmd_enable, boot_on,
					shadow_config[AREA_MSB:AREA_LSB], 2'b00};
			end else if (bus.reg_addr == PORT_CTRL_ADDR) begin
				bus.reg_rdata <= serial_mode ? {6'h00, port_input_ctrl_reg} : 8'h00;
			end else if (bus.reg_addr == SYS_CFG3_ADDR) begin
				bus.reg_rdata <= system_config_three;
			end else begin
				// standby register, system commit register and unmapped read zero
				bus.reg_rdata <= 8'h00;
			end
		end
	end

	assign bus.vec_from_ram = vec_ram;
	assign bus.cmd_armed    = cmd_enable;
	assign bus.flash_busy   = busy_q;

	// port input gating; receive stays live so the loader can talk
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			port_gated           <= '0;
			serial_clock_gated   <= 1'b0;
			serial_receive_gated <= 1'b0;
		end else begin
			serial_receive_gated <= sync_pins[PORT_W];
			if (serial_mode) begin
				port_gated <= port_input_ctrl_reg[PORT_GEN_BIT]
					? sync_pins[PORT_W-1:0] : '0;
				serial_clock_gated <= port_input_ctrl_reg[PORT_SCLK_BIT]
					& sync_pins[PORT_W+1];
			end else begin
				port_gated         <= sync_pins[PORT_W-1:0];
				serial_clock_gated <= sync_pins[PORT_W+1];
			end
		end
	end

endmodule

// File: src/cpu_port_master.sv
`timescale 1ns/1ps
// core-side end: turns user operations into register and memory transfers
module cpu_port_master
	import flash_ctrl_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        resetn,
	cpu_flash_if.host        bus,
	input  wire logic        op_valid,
	input  wire op_type      op_code,
	input  wire logic [15:0] op_addr,
	input  wire logic [7:0]  op_wdata,
	input  wire logic        op_space_code,
	input  wire logic        op_from_ram,
	output logic             op_ready,
	output logic [7:0]       rd_data,
	output logic             rd_valid,
	output logic             armed
);

	host_state_type state;
	logic [2:0]     prog_val;
	logic [4:0]     low_fields;

	assign op_ready = (state == ST_IDLE);
	assign armed    = bus.cmd_armed;

	// sequencer for plain transfers and the lock/unlock pairs
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state           <= ST_IDLE;
			prog_val        <= PROG_PROT;
			low_fields      <= 5'h00;
			bus.reg_wr      <= 1'b0;
			bus.reg_rd      <= 1'b0;
			bus.reg_addr    <= 16'h0000;
			bus.reg_wdata   <= 8'h00;
			bus.reg_src_ram <= 1'b0;
			bus.mem_req     <= 1'b0;
			bus.mem_wr      <= 1'b0;
			bus.mem_code    <= 1'b0;
			bus.mem_addr    <= 16'h0000;
			bus.mem_wdata   <= 8'h00;
			bus.irq_vec     <= 1'b0;
		end else begin
			bus.reg_wr  <= 1'b0;
			bus.reg_rd  <= 1'b0;
			bus.mem_req <= 1'b0;
			bus.irq_vec <= 1'b0;
			case (state)
				ST_IDLE: begin
					if (op_valid) begin
						bus.reg_addr    <= op_addr;
						bus.reg_wdata   <= op_wdata;
						bus.reg_src_ram <= op_from_ram;
						bus.mem_addr    <= op_addr;
						bus.mem_wdata   <= op_wdata;
						bus.mem_code    <= op_space_code;
						bus.mem_wr      <= (op_code == OP_MEM_WR);
						low_fields      <= op_wdata[4:0];
						if (op_code == OP_REG_WR) begin
							bus.reg_wr <= 1'b1;
						end else if (op_code == OP_REG_RD) begin
							bus.reg_rd <= 1'b1;
						end else if (op_code == OP_MEM_RD || op_code == OP_MEM_WR) begin
							bus.mem_req <= 1'b1;
						end else if (op_code == OP_FETCH) begin
							bus.mem_req  <= 1'b1;
							bus.mem_code <= 1'b1;
						end else if (op_code == OP_IRQ) begin
							bus.irq_vec <= 1'b1;
						end else if (op_code == OP_UNLOCK) begin
							prog_val <= PROG_EN;
							state    <= ST_STAGE;
						end else begin
							prog_val <= PROG_PROT;
							state    <= ST_DRAIN;
						end
					end
				end
				ST_DRAIN: begin
					if (!bus.flash_busy) begin
						state <= ST_STAGE;
					end
				end
				ST_STAGE: begin
					bus.reg_wr    <= 1'b1;
					bus.reg_addr  <= STAGED_ADDR;
					bus.reg_wdata <= {prog_val, low_fields};
					state         <= ST_COMMIT;
				end
				ST_COMMIT: begin
					bus.reg_wr    <= 1'b1;
					bus.reg_addr  <= COMMIT_ADDR;
					bus.reg_wdata <= CFG_KEY;
					state         <= ST_IDLE;
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// reset leaves protection on; user locks after each write session
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rd_data  <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= bus.reg_rvalid;
			if (bus.reg_rvalid) begin
				rd_data <= bus.reg_rdata;
			end
		end
	end

endmodule

// File: tb/flash_ctrl_monitor.sv
`timescale 1ns/1ps
// watches the core-to-flash interface between the two ends
module flash_ctrl_monitor
	import flash_ctrl_pkg::*;
(
	input wire logic        clk,
	input wire logic        resetn,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [15:0] reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic [7:0]  reg_rdata,
	input wire logic        reg_rvalid,
	input wire logic        cmd_armed,
	input wire logic        vec_from_ram
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);

	// key writes as plain levels so that $past can look back at them
	wire logic key_cmd     = reg_wr && reg_addr == COMMIT_ADDR && reg_wdata == CFG_KEY;
	wire logic sys_key_cmd = reg_wr && reg_addr == SYS_COMMIT_ADDR && reg_wdata == SYS_KEY;

	// the two steps of a configuration change: stage a field, then the key
	sequence key_wr;
		reg_wr && reg_addr == COMMIT_ADDR && reg_wdata == CFG_KEY;
	endsequence
	sequence stage_wr(f);
		reg_wr && reg_addr == STAGED_ADDR && reg_wdata[PROG_MSB:PROG_LSB] == f;
	endsequence

	arm_seq_a: assert property (stage_wr(PROG_EN) ##1 key_wr |=> cmd_armed)
		else $error("unlock sequence left commands disabled");
	prot_seq_a: assert property (stage_wr(PROG_PROT) ##1 key_wr |=> !cmd_armed)
		else $error("protect sequence left commands enabled");
	// the shadow only moves on the key, so a stray write cannot unprotect
	armed_cause_a: assert property ($changed(cmd_armed) |-> $past(key_cmd))
		else $error("command enable moved without the key");
	bad_key_a: assert property (
		reg_wr && reg_addr == COMMIT_ADDR && reg_wdata != CFG_KEY |=> $stable(cmd_armed))
		else $error("wrong commit value changed the shadow");
	stage_only_a: assert property (reg_wr && reg_addr == STAGED_ADDR |=> $stable(cmd_armed))
		else $error("staged write took effect before the key");
	mon_read_a: assert property (
		reg_rd && reg_addr == COMMIT_ADDR
		|=> reg_rvalid && reg_rdata[7:6] == 2'b00 && reg_rdata[MON_EN_BIT] == cmd_armed)
		else $error("monitor read disagrees with the shadow");
	sb_read_a: assert property (
		reg_rd && reg_addr == STANDBY_ADDR |=> reg_rvalid && reg_rdata == 8'h00)
		else $error("standby register did not read zero");
	vec_cause_a: assert property ($changed(vec_from_ram) |-> $past(sys_key_cmd))
		else $error("vector select moved without the system key");
	rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
		else $error("read answer without a read");
endmodule

// File: tb/tb_flash_map_protect_ctrl.sv
`timescale 1ns/1ps
// both ends joined; the bench drives the core side and the pins
module tb_flash_map_protect_ctrl;
	import flash_ctrl_pkg::*;
	logic        clk, resetn, op_valid, op_space_code, op_from_ram, op_ready, rd_valid;
	op_type      op_code;
	logic [15:0] op_addr, flash_addr, c_addr;
	logic [7:0]  op_wdata, rd_data, port_pins, port_gated, flash_wdata, c_rd, c_wd;
	logic        array_busy, spm_pin, serial_clock_pin, serial_receive_pin, armed;
	logic        flash_cs, flash_we, flash_code_bank, ram_cs, boot_cs, cmd_enable;
	logic        standby_reset, serial_mode, serial_clock_gated, serial_receive_gated;
	logic        c_fl, c_we, c_bank, c_ram, c_boot, c_sr;
	logic [31:0] seed = 32'h083B;
	logic [31:0] r;
	int          num_errors = 0;
	int          compares = 0;
	int          cycles = 0;
	// reference model state
	int m_armed, m_area, m_boot, m_ram, m_vec, m_sb, m_spm, m_staged, m_sys;

	cpu_flash_if bus ();
	flash_map_protect_ctrl #(.PORT_W(8)) flash_map_protect_ctrl_inst (.clk(clk), .resetn(resetn),
		.bus(bus.device), .array_busy(array_busy), .spm_pin(spm_pin), .port_pins(port_pins),
		.serial_clock_pin(serial_clock_pin), .serial_receive_pin(serial_receive_pin),
		.flash_cs(flash_cs), .flash_we(flash_we), .flash_code_bank(flash_code_bank),
		.flash_addr(flash_addr), .flash_wdata(flash_wdata), .ram_cs(ram_cs), .boot_cs(boot_cs),
		.cmd_enable(cmd_enable), .standby_reset(standby_reset), .serial_mode(serial_mode),
		.port_gated(port_gated), .serial_clock_gated(serial_clock_gated),
		.serial_receive_gated(serial_receive_gated));
	cpu_port_master cpu_port_master_inst (.clk(clk), .resetn(resetn), .bus(bus.host),
		.op_valid(op_valid), .op_code(op_code), .op_addr(op_addr), .op_wdata(op_wdata),
		.op_space_code(op_space_code), .op_from_ram(op_from_ram), .op_ready(op_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .armed(armed));
	flash_ctrl_monitor flash_ctrl_monitor_inst (.clk(clk), .resetn(resetn), .reg_wr(bus.reg_wr),
		.reg_rd(bus.reg_rd), .reg_addr(bus.reg_addr), .reg_wdata(bus.reg_wdata),
		.reg_rdata(bus.reg_rdata), .reg_rvalid(bus.reg_rvalid), .cmd_armed(bus.cmd_armed),
		.vec_from_ram(bus.vec_from_ram));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// hang guard, well above the thousand or so cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 8000) begin
			num_errors++;
			close_out();
		end
	end

	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic close_out();
		if (num_errors == 0 && compares > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// register side of the model: staged copy moves to the shadow on the key only
	function automatic void model_wr(input logic [15:0] a, input logic [7:0] d, input logic fr);
		case (a)
			STAGED_ADDR: m_staged = d;
			COMMIT_ADDR: if (d == CFG_KEY) begin
				m_armed = (m_staged[7:5] == 5);
				m_boot = m_staged[4];
				m_area = m_staged[3:2];
			end
			SYS_CFG3_ADDR: m_sys = d;
			SYS_COMMIT_ADDR: if (d == SYS_KEY) begin
				m_ram = m_sys[0];
				m_vec = m_sys[1];
			end
			STANDBY_ADDR: if (fr) m_sb = d[0];
			default: ;
		endcase
	endfunction

	// one host operation; pulses are gathered over the cycles that follow
	task automatic do_op(input op_type code, input logic [15:0] a, input logic [7:0] d,
		input logic sc, input logic fr);
		int n;
		n = 0;
		while (op_ready !== 1'b1 && n < 100) begin
			@(negedge clk);
			n++;
		end
		op_code = code;
		op_addr = a;
		op_wdata = d;
		op_space_code = sc;
		op_from_ram = fr;
		op_valid = 1'b1;
		@(negedge clk);
		op_valid = 1'b0;
		{c_fl, c_we, c_bank, c_ram, c_boot, c_sr} = 6'h00;
		c_rd = 8'hXX;
		{c_addr, c_wd} = 24'hXXXXXX;
		repeat (5) begin
			@(negedge clk);
			if (flash_cs === 1'b1) {c_addr, c_wd} = {flash_addr, flash_wdata};
			c_fl = c_fl | flash_cs;
			c_we = c_we | flash_we;
			c_bank = c_bank | (flash_cs & flash_code_bank);
			c_ram = c_ram | ram_cs;
			c_boot = c_boot | boot_cs;
			c_sr = c_sr | standby_reset;
			if (rd_valid === 1'b1) c_rd = rd_data;
		end
		case (code)
			OP_REG_WR: model_wr(a, d, fr);
			OP_UNLOCK, OP_LOCK: begin
				model_wr(STAGED_ADDR, {code == OP_UNLOCK ? PROG_EN : PROG_PROT, d[4:0]}, 1'b0);
				model_wr(COMMIT_ADDR, CFG_KEY, 1'b0);
			end
			OP_IRQ: if (m_vec == 0) m_sb = 0;
			default: ;
		endcase
	endtask

	task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic fr);
		do_op(OP_REG_WR, a, d, 1'b0, fr);
	endtask

	task automatic rd_mon();
		do_op(OP_REG_RD, COMMIT_ADDR, 8'h00, 1'b0, 1'b0);
		check(c_rd & 8'hFC, {2'b00, m_armed[0], m_boot[0] | m_spm[0], m_area[1:0], 2'b00}, "monitor");
		check(armed, m_armed[0], "armed");
		// the staged copy reads back as written, boot bit forced in serial mode
		do_op(OP_REG_RD, STAGED_ADDR, 8'h00, 1'b0, 1'b0);
		check(c_rd, m_staged[7:0] | {3'h0, m_spm[0], 4'h0}, "staged read");
	endtask

	// memory transfer checked against the expected decode of the model
	task automatic mem(input logic [15:0] a, input logic wr_op, input logic code);
		int ram, boot, fl;
		r = rnd();
		do_op(wr_op ? OP_MEM_WR : OP_MEM_RD, a, r[7:0], code, 1'b0);
		ram = a >= RAM_LO && a <= RAM_HI && (!code || m_ram || m_spm);
		boot = a >= BOOT_LO && a <= (code && m_spm ? BOOT_CODE_HI : BOOT_DATA_HI) && (m_boot || m_spm);
		fl = a >= FLASH_LO && !boot;
		check(c_ram, ram, "ram select");
		check(c_boot, boot, "boot select");
		check(c_fl, fl && !m_sb, "flash select");
		check(c_sr, fl && m_sb, "standby reset");
		check(c_we, fl && !m_sb && wr_op && !code && m_armed, "flash write");
		if (fl && !m_sb) check(c_bank, code || (a >= WIN_LO && m_area == 2), "bank");
		if (fl && !m_sb) check(c_addr, a, "flash address");
		if (fl && !m_sb) check(c_wd, r[7:0], "flash data");
	endtask

	task automatic do_reset(input logic spm);
		resetn = 1'b0;
		spm_pin = spm;
		{m_armed, m_area, m_boot, m_ram, m_vec, m_sb, m_sys} = '0;
		m_staged = STAGED_RESET;
		m_spm = spm;
		repeat (10) @(negedge clk);
		resetn = 1'b1;
		repeat (5) @(negedge clk);
		check(serial_mode, spm, "strap mode");
	endtask

	initial begin
		{op_valid, op_space_code, op_from_ram, array_busy} = 4'h0;
		{serial_clock_pin, serial_receive_pin, port_pins} = 10'h000;
		op_code = OP_REG_RD;
		op_addr = 16'h0000;
		op_wdata = 8'h00;
		do_reset(1'b0);
		check(cmd_enable, 8'h00, "reset enable");
		rd_mon();
		// program codes 101 and 010, areas 00 and 10 and a random boot bit through wrong and right keys
		for (int i = 0; i < 12; i++) begin
			r = rnd();
			wr(STAGED_ADDR, {i[0] ? PROG_EN : PROG_PROT, r[4], i[1], 3'h0}, 1'b0);
			wr(COMMIT_ADDR, r[15:8] == CFG_KEY ? 8'h00 : r[15:8], 1'b0);
			check(cmd_enable, m_armed, "wrong key");
			wr(COMMIT_ADDR, CFG_KEY, 1'b0);
			check(cmd_enable, m_armed, "key");
			rd_mon();
			mem({2'b11, r[29:16]}, 1'b1, 1'b0);
			mem({2'b11, r[29:16]}, 1'b1, 1'b1);
			mem({4'h1, r[27:16]}, 1'b0, 1'b0);
			mem({4'h1, r[27:16]}, 1'b0, 1'b1);
		end
		mem(16'h0FBF, 1'b0, 1'b1);
		for (int v = 0; v < 2; v++) begin
			wr(SYS_CFG3_ADDR, v[0] ? 8'h03 : 8'h01, 1'b0);
			wr(SYS_COMMIT_ADDR, SYS_KEY, 1'b0);
			mem(RAM_LO, 1'b0, 1'b1);
			wr(STANDBY_ADDR, 8'h01, 1'b0);
			mem(16'hD000, 1'b0, 1'b0);
			wr(STANDBY_ADDR, 8'h01, 1'b1);
			do_op(OP_REG_RD, STANDBY_ADDR, 8'h00, 1'b0, 1'b0);
			check(c_rd, 8'h00, "standby read");
			mem(16'hE000, 1'b0, 1'b0);
			do_op(OP_IRQ, 16'h0000, 8'h00, 1'b0, 1'b0);
			mem(16'hF000, 1'b0, 1'b0);
		end
		wr(STANDBY_ADDR, 8'h00, 1'b1);
		wr(SYS_CFG3_ADDR, 8'h00, 1'b0);
		wr(SYS_COMMIT_ADDR, SYS_KEY, 1'b0);
		do_op(OP_UNLOCK, 16'h0000, 8'h00, 1'b0, 1'b0);
		array_busy = 1'b1;
		do_op(OP_LOCK, 16'h0000, 8'h00, 1'b0, 1'b0);
		repeat (4) @(negedge clk);
		check(cmd_enable, 8'h01, "busy lock");
		array_busy = 1'b0;
		rd_mon();
		do_reset(1'b1);
		ports(0, 0);
		wr(PORT_CTRL_ADDR, 8'h02, 1'b0);
		ports(0, 1);
		wr(PORT_CTRL_ADDR, 8'h03, 1'b0);
		ports(1, 1);
		mem(16'h0100, 1'b0, 1'b1);
		mem(16'h1800, 1'b0, 1'b1);
		mem(16'h1800, 1'b0, 1'b0);
		wr(STAGED_ADDR, STAGED_RESET, 1'b0);
		wr(COMMIT_ADDR, CFG_KEY, 1'b0);
		rd_mon();
		do_reset(1'b0);
		wr(PORT_CTRL_ADDR, 8'h00, 1'b0);
		ports(1, 1);
		close_out();
	end

	// inputs settle through the synchronisers before the gated copies are compared
	task automatic ports(input int gen, input int sck);
		r = rnd();
		port_pins = r[7:0];
		serial_clock_pin = r[8];
		serial_receive_pin = r[9];
		repeat (4) @(negedge clk);
		check(port_gated, gen ? r[7:0] : 8'h00, "port gate");
		check(serial_clock_gated, sck ? r[8] : 1'b0, "clock gate");
		check(serial_receive_gated, r[9], "receive gate");
	endtask
endmodule
